//--- hw/spgc_pad.sv
module spgc_pad #(
  parameter int W = 8
) (
  input  wire logic [W-1:0] dir,
  input  wire logic [W-1:0] pullup_bit,
  input  wire logic [W-1:0] latch,
  input  wire logic [W-1:0] level,
  output logic      [W-1:0] pin_out,
  output logic      [W-1:0] pin_oe,
  output logic      [W-1:0] pin_pullup_en,
  output logic      [W-1:0] rd_value
);

  initial begin
    if (W < 1 || W > spgc_pkg::SPGC_PORT_W) $error("spgc_pad: width out of range");
  end

  always_comb begin
    for (int b = 0; b < W; b++) begin
      pin_out[b]       = latch[b];                                   // see R2
      pin_oe[b]        = (dir[b] == spgc_pkg::SPGC_DIR_OUT);         // see R2
      // an output pin never has its pull-up on, whatever the pull-up bit says
      pin_pullup_en[b] = !pin_oe[b] && (pullup_bit[b] == spgc_pkg::SPGC_PU_ON); // see R3 see R5
      rd_value[b]      = pin_oe[b] ? latch[b] : level[b];            // see R4 see R9
    end
  end

endmodule : spgc_pad

//--- hw/spgc_pkg.sv
// Summary of operation
// R1 - The block controls 46 two-way pins: ports 0 to 4 have eight pins each and port 5 has six.
// R2 - A direction bit of 0 (reset) makes the pin an input; 1 makes it a push-pull output of its latch.
// R3 - The pull-up bit acts only on an input pin: 0 leaves it high impedance, 1 turns the pull-up on.
// R4 - Reading the data bit of an output pin returns the latch, not the pin level.
// R5 - An input pin with its pull-up on reads high unless something outside pulls it low.
// R6 - Software should make every unused pin, and every bit without a pin, a push-pull output; port 5 direction bits 7 and 6 are masked and stay 0.
// R7 - The port 0 data register sits at index 80h, is read and write, and clears to zero at reset.
// R8 - Ports 1 to 5 each have a data register of latches; port 5 keeps latch bits 5 to 0 only.
// R9 - Reading the data bit of an input pin returns the synchronised level on the pin.
package spgc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // geometry
  localparam int SPGC_NUM_PORTS = 6;
  localparam int SPGC_PORT_W    = 8;
  localparam int SPGC_P5_W      = 6;
  localparam int SPGC_NUM_PINS  = 46;
  localparam int SPGC_IDX_W     = 8;
  localparam int SPGC_ADDR_W    = 10;
  localparam int SPGC_DATA_W    = 32;

  ////////////////////////////////////////////////////////////////////////////
  // register indices; the byte address is four times the index
  localparam logic [7:0] SPGC_IDX_P0_DATA = 8'h80;
  localparam logic [7:0] SPGC_IDX_P1_DATA = 8'h90;
  localparam logic [7:0] SPGC_IDX_P2_DATA = 8'ha0;
  localparam logic [7:0] SPGC_IDX_P3_DATA = 8'hb0;
  localparam logic [7:0] SPGC_IDX_P4_DATA = 8'hc0;
  localparam logic [7:0] SPGC_IDX_P5_DATA = 8'hd8;
  localparam logic [7:0] SPGC_IDX_P0_DIR  = 8'h9a;
  localparam logic [7:0] SPGC_IDX_P1_DIR  = 8'h91;
  localparam logic [7:0] SPGC_IDX_P2_DIR  = 8'ha1;
  localparam logic [7:0] SPGC_IDX_P3_DIR  = 8'hb1;
  localparam logic [7:0] SPGC_IDX_P4_DIR  = 8'hc1;
  localparam logic [7:0] SPGC_IDX_P5_DIR  = 8'hd9;
  localparam logic [7:0] SPGC_IDX_P0_PU   = 8'h9b;
  localparam logic [7:0] SPGC_IDX_P1_PU   = 8'h92;
  localparam logic [7:0] SPGC_IDX_P2_PU   = 8'ha2;
  localparam logic [7:0] SPGC_IDX_P3_PU   = 8'hb2;
  localparam logic [7:0] SPGC_IDX_P4_PU   = 8'hc2;
  localparam logic [7:0] SPGC_IDX_P5_PU   = 8'hda;
  // read-only raw pin levels, one index per port from this base
  localparam logic [7:0] SPGC_IDX_LEVEL_BASE = 8'he0;

  localparam logic [5:0][7:0] SPGC_DATA_IDX = {SPGC_IDX_P5_DATA, SPGC_IDX_P4_DATA,
      SPGC_IDX_P3_DATA, SPGC_IDX_P2_DATA, SPGC_IDX_P1_DATA, SPGC_IDX_P0_DATA};
  localparam logic [5:0][7:0] SPGC_DIR_IDX = {SPGC_IDX_P5_DIR, SPGC_IDX_P4_DIR,
      SPGC_IDX_P3_DIR, SPGC_IDX_P2_DIR, SPGC_IDX_P1_DIR, SPGC_IDX_P0_DIR};
  localparam logic [5:0][7:0] SPGC_PU_IDX = {SPGC_IDX_P5_PU, SPGC_IDX_P4_PU,
      SPGC_IDX_P3_PU, SPGC_IDX_P2_PU, SPGC_IDX_P1_PU, SPGC_IDX_P0_PU};

  ////////////////////////////////////////////////////////////////////////////
  // values after reset and field meaning
  localparam logic [7:0] SPGC_RST_DATA = 8'h00;
  localparam logic [7:0] SPGC_RST_DIR  = 8'h00;
  localparam logic [7:0] SPGC_RST_PU   = 8'h00;
  localparam logic       SPGC_DIR_OUT  = 1'b1;
  localparam logic       SPGC_PU_ON    = 1'b1;

  typedef enum logic [2:0] {
    SPGC_KIND_NONE,
    SPGC_KIND_DATA,
    SPGC_KIND_DIR,
    SPGC_KIND_PU,
    SPGC_KIND_LEVEL
  } spgc_kind_e;

endpackage : spgc_pkg

//--- hw/spgc_sync.sv
module spgc_sync #(
  parameter int W = 8
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         pclk_en,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] stage1;

  initial begin
    if (W < 1) $error("spgc_sync: width must be at least one");
  end

  // stage1 feeds only the second flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage1   <= '0;
      sync_out <= '0;
    end else if (pclk_en) begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end

endmodule : spgc_sync

//--- hw/spgc_top.sv
module spgc_top #(
  parameter int ADDR_W = spgc_pkg::SPGC_ADDR_W
) (
  input  wire logic                              pclk,
  input  wire logic                              presetn,
  input  wire logic                              pclk_en,
  input  wire logic                              psel,
  input  wire logic                              penable,
  input  wire logic                              pwrite,
  input  wire logic [ADDR_W-1:0]                 paddr,
  input  wire logic [spgc_pkg::SPGC_DATA_W-1:0]  pwdata,
  input  wire logic [3:0]                        pstrb,
  output logic      [spgc_pkg::SPGC_DATA_W-1:0]  prdata,
  output logic                                   pready,
  output logic                                   pslverr,
  input  wire logic [spgc_pkg::SPGC_NUM_PINS-1:0] pin_in,
  output logic      [spgc_pkg::SPGC_NUM_PINS-1:0] pin_out,
  output logic      [spgc_pkg::SPGC_NUM_PINS-1:0] pin_oe,
  output logic      [spgc_pkg::SPGC_NUM_PINS-1:0] pin_pullup_en
);

  ////////////////////////////////////////////////////////////////////////////
  // local sizes

  localparam int NP     = spgc_pkg::SPGC_NUM_PORTS;
  localparam int PW     = spgc_pkg::SPGC_PORT_W;
  localparam int NPINS  = spgc_pkg::SPGC_NUM_PINS;
  localparam int IDX_W  = spgc_pkg::SPGC_IDX_W;
  localparam int DW     = spgc_pkg::SPGC_DATA_W;

  initial begin
    if (ADDR_W < IDX_W + 2 || ADDR_W > 32) begin
      $error("spgc_top: ADDR_W must be between 10 and 32");
    end
    if ((NP - 1) * PW + spgc_pkg::SPGC_P5_W != NPINS) begin
      $error("spgc_top: pin count does not match the port widths");
    end
  end

  // implemented bits of each port; port 5 stops at bit 5
  function automatic logic [7:0] port_mask(input int p);
    logic [7:0] m;
    m = 8'hff;
    if (p == NP - 1) begin
      m = 8'hff >> (PW - spgc_pkg::SPGC_P5_W);                       // see R8
    end
    return m;
  endfunction : port_mask

  ////////////////////////////////////////////////////////////////////////////
  // register state

  logic [7:0] dir_q   [NP];
  logic [7:0] pu_q    [NP];
  logic [7:0] latch_q [NP];
  logic [7:0] rd_val  [NP];
  logic [7:0] lvl_val [NP];

  logic [NPINS-1:0] pin_level;

  ////////////////////////////////////////////////////////////////////////////
  // pin inputs: two flops before any logic reads them

  spgc_sync #(
    .W (NPINS)
  ) u_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .pclk_en  (pclk_en),
    .async_in (pin_in),
    .sync_out (pin_level)
  );

  ////////////////////////////////////////////////////////////////////////////
  // pad control, one instance per port

  for (genvar p = 0; p < NP; p++) begin : g_port
    localparam int W    = (p == NP - 1) ? spgc_pkg::SPGC_P5_W : PW;
    localparam int BASE = p * PW;

    logic [W-1:0] rd_w;

    spgc_pad #(
      .W (W)
    ) u_pad (
      .dir           (dir_q[p][W-1:0]),
      .pullup_bit    (pu_q[p][W-1:0]),
      .latch         (latch_q[p][W-1:0]),
      .level         (pin_level[BASE +: W]),
      .pin_out       (pin_out[BASE +: W]),
      .pin_oe        (pin_oe[BASE +: W]),
      .pin_pullup_en (pin_pullup_en[BASE +: W]),
      .rd_value      (rd_w)
    );

    if (W < PW) begin : g_narrow
      // missing bits of a narrow port read as zero
      assign rd_val[p]  = {{(PW - W){1'b0}}, rd_w};                  // see R8
      assign lvl_val[p] = {{(PW - W){1'b0}}, pin_level[BASE +: W]};
    end else begin : g_full
      assign rd_val[p]  = rd_w;                                      // see R1
      assign lvl_val[p] = pin_level[BASE +: W];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // address decode

  spgc_pkg::spgc_kind_e dec_kind;
  logic [2:0]           dec_port;
  logic [IDX_W-1:0]     dec_idx;
  logic                 dec_aligned;

  assign dec_idx     = paddr[IDX_W+1:2];
  // above the index, the address must be zero and word aligned
  assign dec_aligned = (paddr[1:0] == 2'b00) && ((paddr >> (IDX_W + 2)) == '0);

  always_comb begin
    dec_kind = spgc_pkg::SPGC_KIND_NONE;
    dec_port = 3'd0;
    for (int p = 0; p < NP; p++) begin
      if (dec_idx == spgc_pkg::SPGC_DATA_IDX[p]) begin               // see R7 see R8
        dec_kind = spgc_pkg::SPGC_KIND_DATA;
        dec_port = 3'(p);
      end
      if (dec_idx == spgc_pkg::SPGC_DIR_IDX[p]) begin
        dec_kind = spgc_pkg::SPGC_KIND_DIR;
        dec_port = 3'(p);
      end
      if (dec_idx == spgc_pkg::SPGC_PU_IDX[p]) begin
        dec_kind = spgc_pkg::SPGC_KIND_PU;
        dec_port = 3'(p);
      end
      if (dec_idx == spgc_pkg::SPGC_IDX_LEVEL_BASE + IDX_W'(p)) begin
        dec_kind = spgc_pkg::SPGC_KIND_LEVEL;
        dec_port = 3'(p);
      end
    end
    if (!dec_aligned) begin
      dec_kind = spgc_pkg::SPGC_KIND_NONE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb handshake
  // the answer is prepared at the first enabled edge that sees psel, so a
  // stalled clock enable simply stretches the access phase

  logic ans_valid;
  logic access_done;
  logic dec_error;

  // level registers are read-only; writing one is an error
  assign dec_error = (dec_kind == spgc_pkg::SPGC_KIND_NONE)
                  || (pwrite && dec_kind == spgc_pkg::SPGC_KIND_LEVEL);

  assign pready      = pclk_en && ans_valid;
  assign access_done = psel && penable && pready;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ans_valid <= 1'b0;
    end else if (pclk_en) begin
      if (!psel || access_done) begin
        ans_valid <= 1'b0;
      end else begin
        ans_valid <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read data and error answer

  logic [7:0] next_rd_byte;

  always_comb begin
    next_rd_byte = 8'h00;
    case (dec_kind)
      spgc_pkg::SPGC_KIND_DATA:  next_rd_byte = rd_val[dec_port];    // see R4 see R9
      spgc_pkg::SPGC_KIND_DIR:   next_rd_byte = dir_q[dec_port];
      spgc_pkg::SPGC_KIND_PU:    next_rd_byte = pu_q[dec_port];
      spgc_pkg::SPGC_KIND_LEVEL: next_rd_byte = lvl_val[dec_port];
      default:                   next_rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= '0;
      pslverr <= 1'b0;
    end else if (pclk_en) begin
      if (psel && !ans_valid) begin
        prdata  <= pwrite ? '0 : {{(DW - 8){1'b0}}, next_rd_byte};
        pslverr <= dec_error;
      end else if (access_done) begin
        prdata  <= '0;
        pslverr <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register writes; only lane 0 carries register bits

  logic wr_fire;

  assign wr_fire = access_done && pwrite && !dec_error && pstrb[0];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int p = 0; p < NP; p++) begin
        latch_q[p] <= spgc_pkg::SPGC_RST_DATA;                       // see R7
      end
    end else if (pclk_en && wr_fire && dec_kind == spgc_pkg::SPGC_KIND_DATA) begin
      latch_q[dec_port] <= pwdata[7:0] & port_mask(int'(dec_port)); // see R7 see R8
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int p = 0; p < NP; p++) begin
        dir_q[p] <= spgc_pkg::SPGC_RST_DIR;                          // see R2
      end
    end else if (pclk_en && wr_fire && dec_kind == spgc_pkg::SPGC_KIND_DIR) begin
      dir_q[dec_port] <= pwdata[7:0] & port_mask(int'(dec_port));
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int p = 0; p < NP; p++) begin
        pu_q[p] <= spgc_pkg::SPGC_RST_PU;                            // see R3
      end
    end else if (pclk_en && wr_fire && dec_kind == spgc_pkg::SPGC_KIND_PU) begin
      pu_q[dec_port] <= pwdata[7:0] & port_mask(int'(dec_port));
    end
  end

endmodule : spgc_top

//--- testbench/six_port_gpio_control_test.sv
module six_port_gpio_control_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int NP = spgc_pkg::SPGC_NUM_PINS;
  localparam logic [2:0][9:0] BAD = {10'h380, 10'h201, 10'h040};
  logic          pclk      = 1'b0;
  logic          presetn   = 1'b0;
  logic          pclk_en   = 1'b1;
  logic          psel      = 1'b0;
  logic          penable   = 1'b0;
  logic          pwrite    = 1'b0;
  logic [9:0]    paddr     = '0;
  logic [31:0]   pwdata    = '0;
  logic [3:0]    pstrb     = '0;
  logic [NP-1:0] ext_drive = '1;
  logic [NP-1:0] ext_val   = '0;
  logic [31:0]   prdata, rd;
  logic          pready, pslverr, err;
  logic [NP-1:0] pin_in, pin_out, pin_oe, pin_pullup_en;
  logic [47:0]   e;
  logic [7:0]    m, v;
  int            n_fail    = 0;
  int            compares  = 0;
  always #5 pclk = ~pclk;
  spgc_top DUT (.pclk(pclk), .presetn(presetn), .pclk_en(pclk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup_en(pin_pullup_en));
  spgc_board u_board (.pclk(pclk), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_pullup_en(pin_pullup_en), .ext_drive(ext_drive), .ext_val(ext_val), .pin_in(pin_in));
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [9:0] ba(input logic [7:0] i);
    return {i, 2'b00};
  endfunction : ba
  // starts right after an edge; no release, so calls run back to back
  task automatic xfer(input logic w, input logic [9:0] a, input logic [31:0] d,
                      input logic [3:0] s);
    int n;
    if (psel !== 1'b1) @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d; pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 50);
    if (n >= 50) n_fail++;
    rd = prdata;
    err = pslverr;
  endtask : xfer
  task automatic settle;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge pclk);
    @(negedge pclk);
  endtask : settle
  // pins need the two sync stages plus margin before a read sees them
  task automatic drive_ext(input logic [7:0] dr, input logic [7:0] vl);
    settle;
    @(posedge pclk); ext_drive[15:8] <= dr; ext_val[15:8] <= vl;
    repeat (4) @(posedge pclk);
  endtask : drive_ext
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic wrap_up;
    $display("mismatches %0d of %0d compares", n_fail, compares);
    if (n_fail == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : wrap_up
  initial begin
    #100us; n_fail++; wrap_up;
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    for (int p = 0; p < 6; p++) begin
      xfer(1'b0, ba(spgc_pkg::SPGC_DATA_IDX[p]), 32'h0, 4'h0);
      check(64'(rd), 64'h0);
      xfer(1'b0, ba(spgc_pkg::SPGC_DIR_IDX[p]), 32'h0, 4'h0);
      check(64'(rd), 64'h0);
      xfer(1'b0, ba(spgc_pkg::SPGC_PU_IDX[p]), 32'h0, 4'h0);
      check(64'(rd), 64'h0);
    end
    e = '0;
    for (int p = 0; p < 6; p++) begin
      m = (p == 5) ? 8'h3f : 8'hff;
      v = 8'h5a ^ 8'(p);
      xfer(1'b1, ba(spgc_pkg::SPGC_DIR_IDX[p]), 32'hff, 4'h1);
      xfer(1'b1, ba(spgc_pkg::SPGC_DATA_IDX[p]), 32'(v), 4'h1);
      xfer(1'b0, ba(spgc_pkg::SPGC_DIR_IDX[p]), 32'h0, 4'h0);
      check(64'(rd), 64'(m));
      xfer(1'b0, ba(spgc_pkg::SPGC_DATA_IDX[p]), 32'h0, 4'h0);
      check(64'(rd), 64'(v & m));
      e[p*8 +: 8] = v & m;
    end
    settle;
    check(64'(pin_oe), 64'({NP{1'b1}}));
    check(64'(pin_out), 64'(e[NP-1:0]));
    xfer(1'b1, ba(spgc_pkg::SPGC_IDX_P0_DATA), 32'h0, 4'h0);
    xfer(1'b0, ba(spgc_pkg::SPGC_IDX_P0_DATA), 32'h0, 4'h0);
    check(64'(rd), 64'h5a);
    xfer(1'b1, ba(spgc_pkg::SPGC_IDX_P1_DIR), 32'h0, 4'h1);
    xfer(1'b1, ba(spgc_pkg::SPGC_IDX_P1_PU), 32'hff, 4'h1);
    drive_ext(8'h08, 8'h00);
    check(64'(pin_pullup_en[15:8]), 64'hff);
    xfer(1'b0, ba(spgc_pkg::SPGC_IDX_P1_DATA), 32'h0, 4'h0);
    check(64'(rd), 64'hf7);
    xfer(1'b1, ba(spgc_pkg::SPGC_IDX_P1_PU), 32'h0, 4'h1);
    drive_ext(8'hff, 8'h3c);
    xfer(1'b0, ba(spgc_pkg::SPGC_IDX_P1_DATA), 32'h0, 4'h0);
    check(64'(rd), 64'h3c);
    xfer(1'b1, ba(spgc_pkg::SPGC_IDX_P1_PU), 32'hff, 4'h1);
    xfer(1'b1, ba(spgc_pkg::SPGC_IDX_P1_DIR), 32'hff, 4'h1);
    settle;
    check(64'(pin_pullup_en[15:8]), 64'h0);
    for (int i = 0; i < 3; i++) begin
      xfer(1'b1, BAD[i], 32'hff, 4'h1);
      check(64'(err), 64'h1);
    end
    xfer(1'b0, BAD[0], 32'h0, 4'h0);
    check(64'({err, rd}), 64'h1_0000_0000);
    // the raw level of port 0 reads back what its driven pins carry
    xfer(1'b0, BAD[2], 32'h0, 4'h0);
    check(64'({err, rd}), 64'h5a);
    settle;
    fork
      xfer(1'b0, ba(spgc_pkg::SPGC_IDX_P0_DATA), 32'h0, 4'h0);
      begin
        repeat (2) @(posedge pclk);
        pclk_en <= 1'b0;
        repeat (3) @(posedge pclk);
        pclk_en <= 1'b1;
      end
    join
    check(64'(rd), 64'h5a);
    settle;
    @(posedge pclk); presetn <= 1'b0;
    repeat (2) @(posedge pclk); presetn <= 1'b1;
    xfer(1'b0, ba(spgc_pkg::SPGC_IDX_P0_DIR), 32'h0, 4'h0);
    check(64'(rd), 64'h0);
    xfer(1'b0, ba(spgc_pkg::SPGC_IDX_P0_DATA), 32'h0, 4'h0);
    check(64'(rd), 64'h0);
    settle;
    wrap_up;
  end
endmodule : six_port_gpio_control_test

//--- testbench/spgc_board.sv
module spgc_board (
  input  wire logic        pclk,
  input  wire logic [45:0] pin_out,
  input  wire logic [45:0] pin_oe,
  input  wire logic [45:0] pin_pullup_en,
  input  wire logic [45:0] ext_drive,
  input  wire logic [45:0] ext_val,
  output logic      [45:0] pin_in
);
  timeunit 1ns;
  timeprecision 1ps;
  ////////////////////////////////////////////////////////////////////////////
  // a floating pin toggles so no settled level can pass for a real one
  logic [45:0] float_v = '0;
  always_ff @(posedge pclk) float_v <= ~float_v;
  assign pin_in = (pin_oe & pin_out)
      | (~pin_oe & ext_drive & ext_val)
      | (~pin_oe & ~ext_drive & pin_pullup_en)
      | (~pin_oe & ~ext_drive & ~pin_pullup_en & float_v);
endmodule : spgc_board

//--- testbench/spgc_checker.sv
module spgc_checker #(
  parameter int ADDR_W = spgc_pkg::SPGC_ADDR_W
) (
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              pclk_en,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [3:0]        pstrb,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic [45:0]       pin_in,
  input wire logic [45:0]       pin_out,
  input wire logic [45:0]       pin_oe,
  input wire logic [45:0]       pin_pullup_en
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [ADDR_W-1:0] a_d0, a_c0, a_h1, a_d5;
  logic              wr_ok, rd_ok;
  assign a_d0  = ADDR_W'({spgc_pkg::SPGC_IDX_P0_DATA, 2'b00});
  assign a_c0  = ADDR_W'({spgc_pkg::SPGC_IDX_P0_DIR, 2'b00});
  assign a_h1  = ADDR_W'({spgc_pkg::SPGC_IDX_P1_PU, 2'b00});
  assign a_d5  = ADDR_W'({spgc_pkg::SPGC_IDX_P5_DATA, 2'b00});
  assign wr_ok = psel && penable && pready && pwrite && pstrb[0];
  assign rd_ok = psel && penable && pready && !pwrite;
  ////////////////////////////////////////////////////////////////////////////
  property p_rst_quiet;
    $rose(presetn) |-> pin_oe == '0 && pin_pullup_en == '0 && pin_out == '0;
  endproperty
  property p_excl; (pin_oe & pin_pullup_en) == '0; endproperty
  property p_zero_wait; psel && !penable && pclk_en ##1 pclk_en |-> pready; endproperty
  property p_upper0; rd_ok |-> prdata[31:8] == 24'h0; endproperty
  property p_p5_rd; rd_ok && paddr == a_d5 |-> prdata[7:6] == 2'b00; endproperty
  property p_latch_out; wr_ok && paddr == a_d0 |=> pin_out[7:0] == $past(pwdata[7:0]); endproperty
  property p_dir_oe; wr_ok && paddr == a_c0 |=> pin_oe[7:0] == $past(pwdata[7:0]); endproperty
  property p_pu_en;
    wr_ok && paddr == a_h1 |=> pin_pullup_en[15:8] == ($past(pwdata[7:0]) & ~pin_oe[15:8]);
  endproperty
  property p_misalign; psel && penable && pready && paddr[1:0] != 2'b00 |-> pslverr; endproperty
  property p_rd_out;
    rd_ok && paddr == a_d0 && pin_oe[7:0] == 8'hff |-> prdata[7:0] == pin_out[7:0];
  endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("pins active after reset");
  a_excl: assert property (p_excl) else $error("pull-up on a driven pin");
  a_zero_wait: assert property (p_zero_wait) else $error("no ready after setup");
  a_upper0: assert property (p_upper0) else $error("upper read bits set");
  a_p5_rd: assert property (p_p5_rd) else $error("port 5 top bits set");
  a_latch_out: assert property (p_latch_out) else $error("latch not on pins");
  a_dir_oe: assert property (p_dir_oe) else $error("direction not on enables");
  a_pu_en: assert property (p_pu_en) else $error("pull-up enable wrong");
  a_misalign: assert property (p_misalign) else $error("misaligned access accepted");
  a_rd_out: assert property (p_rd_out) else $error("output pin read not latch");
  c_wr: cover property (wr_ok && paddr == a_d0);
  c_err: cover property (rd_ok && pslverr);
  c_stall: cover property (psel && penable && !pclk_en);
endmodule : spgc_checker

bind spgc_top spgc_checker #(.ADDR_W(ADDR_W)) u_chk (.pclk(pclk), .presetn(presetn),
  .pclk_en(pclk_en), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup_en(pin_pullup_en));
